//--- shc_consts.svh
// Purpose: offsets, field positions, reset values and timing counts for the sensor hub control bank
// Assumes: 10 MHz clock
// Notes:   definitions only
`ifndef SHC_CONSTS_SVH
`define SHC_CONSTS_SVH

// ==========================================================
// register offsets
`define SHC_OFS_PACING        8'h67
`define SHC_OFS_PATH_RESET    8'h68
`define SHC_OFS_DETECT        8'h69
`define SHC_OFS_FEATURE       8'h6a

// ==========================================================
// field positions and writable masks
`define SHC_PACE_DEFER_BIT    7
`define SHC_PACE_MASK         8'h9f
`define SHC_DET_MASK          8'h3f
`define SHC_FEAT_MASK         8'h70
`define SHC_FEAT_FIFO_ON_BIT  6
`define SHC_FEAT_AUX_ON_BIT   5
`define SHC_FEAT_PORT_DIS_BIT 4
`define SHC_FEAT_FIFO_CLR_BIT 2
`define SHC_FEAT_AUX_CLR_BIT  1
`define SHC_FEAT_CHAIN_CLR_BIT 0
`define SHC_RATE_CLR_BIT      2
`define SHC_ACCEL_CLR_BIT     1
`define SHC_TEMP_CLR_BIT      0

// ==========================================================
// reset values
`define SHC_RST_BYTE          8'h00

// ==========================================================
// timing
`define SHC_CLK_HZ            10000000
`define SHC_WAKE_BASE_MS      4
`define SHC_WAKE_STEP_MS      1
`define SHC_CYC_PER_MS        ((`SHC_CLK_HZ / 1000))
`define SHC_WAKE_BASE_CYC     (`SHC_WAKE_BASE_MS * `SHC_CYC_PER_MS)
`define SHC_WAKE_STEP_CYC     (`SHC_WAKE_STEP_MS * `SHC_CYC_PER_MS)
`define SHC_FLUSH_SAMPLES     4
`define SHC_NUM_TARGETS       5

`endif

//--- shc_pkg.sv
// Purpose: types for the sensor hub control bank
// Assumes: nothing
// Notes:   constants live in shc_consts.svh
package shc_pkg;
	typedef enum logic [1:0] {
		SHC_WAKE_IDLE  = 2'b00,
		SHC_WAKE_WAIT  = 2'b01,
		SHC_WAKE_FLUSH = 2'b10,
		SHC_WAKE_RUN   = 2'b11
	} shc_wake_t;
	typedef logic [7:0] shc_byte_t;
endpackage : shc_pkg

//--- shc_control_regs.sv
// Purpose: four control registers plus the pacing, wake and detection-counter logic they steer
// Assumes: host port on clk; sensor strobes synchronous to clk; aux lines are pins
// Notes:   wake delay exceeds 4096 cycles, so its counts are top-level parameters
`timescale 1ns/100ps
`include "shc_consts.svh"

// What this block does
// - with deferral set, shadow copy waits until the whole transaction set has arrived.
// - five per-target enables each slow that target's access.
// - a slowed target is accessed once every one plus divider samples.
// - base sample tick comes from the sample-rate divider and filter setting.
// - path reset register bits 2,1,0 clear rate, accel and temp paths.
// - a path clear returns converters and filters to power-up state.
// - path clears leave the measurement registers untouched.
// - accel wake delay is 4 ms plus 0 to 3 ms at 1 ms steps.
// - filters are flushed with new samples before detectors start.
// - detection registers only after threshold met over configured sample count.
// - each qualifying sample adds one to its detection counter, which holds at 255.
// - failing sample decrements by select: 0 reset, 1, 2 or 4.
// - select zero forces the counter to zero on any failing sample.
// - detection register holds wake delay, freefall and motion selects at 5:4,3:2,1:0.
// - aux master enable bit 5 makes the device master of the aux bus.
// - with master off, aux lines follow the primary bus lines.
// - feature register bit 6 enables the FIFO.
// - feature register holds FIFO, aux master and sensor chain reset bits.
// - reset bits 2,1,0 trigger their reset then clear themselves.
// - FIFO reset acts only while FIFO enable is zero.
// - external register allocation recomputed only when all targets off or master reset.
module shc_control_regs
	import shc_pkg::*;
#(
	parameter int WAKE_BASE_CYC = `SHC_WAKE_BASE_CYC,
	parameter int WAKE_STEP_CYC = `SHC_WAKE_STEP_CYC
)(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rstn,
	// host register port
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	// sample pacing inputs
	input  wire logic [7:0] sample_rate_divider,
	input  wire logic [2:0] lowpass_filter_config,
	input  wire logic [4:0] slow_access_divider,
	input  wire logic       sensor_tick,
	// aux master handshakes
	input  wire logic [4:0] target_enabled,
	input  wire logic       aux_set_done,
	output logic      [4:0] target_access,
	output logic            shadow_copy,
	output logic            alloc_recompute,
	// detection inputs and outputs
	input  wire logic       accel_wake,
	input  wire logic       accel_sample,
	input  wire logic       freefall_qualify,
	input  wire logic       motion_qualify,
	input  wire logic [7:0] freefall_duration,
	input  wire logic [7:0] motion_duration,
	output logic            detect_active,
	output logic      [7:0] freefall_count,
	output logic      [7:0] motion_count,
	output logic            freefall_detect,
	output logic            motion_detect,
	// reset pulses toward the sensor chains, then feature enable levels
	output logic            rate_path_clear,
	output logic            accel_path_clear,
	output logic            temp_path_clear,
	output logic            sensor_regs_clear,
	output logic            fifo_clear,
	output logic            aux_master_clear,
	output logic            fifo_on,
	output logic            aux_master_on,
	output logic            primary_port_disable,
	// aux bus pins
	input  wire logic       primary_data_in,
	input  wire logic       primary_clock_in,
	input  wire logic       master_data_out,
	input  wire logic       master_clock_out,
	output logic            aux_bus_data_line,
	output logic            aux_bus_clock_line
);

	// ==========================================================
	// registers
	shc_byte_t   pacing_reg;
	shc_byte_t   detect_reg;
	shc_byte_t   feature_reg;
	logic [7:0]  rdata_reg;
	logic        wr_pace;
	logic        wr_path;
	logic        wr_det;
	logic        wr_feat;

	assign wr_pace = wr && (addr == `SHC_OFS_PACING);
	assign wr_path = wr && (addr == `SHC_OFS_PATH_RESET);
	assign wr_det  = wr && (addr == `SHC_OFS_DETECT);
	assign wr_feat = wr && (addr == `SHC_OFS_FEATURE);

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			pacing_reg <= `SHC_RST_BYTE;
		else if (wr_pace)
			pacing_reg <= wdata & `SHC_PACE_MASK;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			detect_reg <= `SHC_RST_BYTE;
		else if (wr_det)
			detect_reg <= wdata & `SHC_DET_MASK;
	end

	// fifo and master enables kept; reset bits never stored, so they read zero
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			feature_reg <= `SHC_RST_BYTE;
		else if (wr_feat)
			feature_reg <= wdata & `SHC_FEAT_MASK;
	end

	// read data one cycle later; path reset reads zero as write-only
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			rdata_reg <= 8'h00;
		else if (rd)
		begin
			unique case (addr)
				`SHC_OFS_PACING:  rdata_reg <= pacing_reg;
				`SHC_OFS_DETECT:  rdata_reg <= detect_reg;
				`SHC_OFS_FEATURE: rdata_reg <= feature_reg;
				default:          rdata_reg <= 8'h00;
			endcase
		end
		else
			rdata_reg <= 8'h00;
	end
	assign rdata = rdata_reg;

	// ==========================================================
	// reset pulses
	logic [6:0] pulse_reg;
	// chains go back to power-up state
	// fifo reset gated by fifo enable
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			pulse_reg <= 7'h00;
		else
		begin
			pulse_reg[0] <= wr_path && wdata[`SHC_RATE_CLR_BIT];
			pulse_reg[1] <= wr_path && wdata[`SHC_ACCEL_CLR_BIT];
			pulse_reg[2] <= wr_path && wdata[`SHC_TEMP_CLR_BIT];
			pulse_reg[3] <= wr_feat && wdata[`SHC_FEAT_CHAIN_CLR_BIT];
			pulse_reg[4] <= wr_feat && wdata[`SHC_FEAT_FIFO_CLR_BIT] && !feature_reg[`SHC_FEAT_FIFO_ON_BIT];
			pulse_reg[5] <= wr_feat && wdata[`SHC_FEAT_AUX_CLR_BIT];
			pulse_reg[6] <= (wr_feat && wdata[`SHC_FEAT_AUX_CLR_BIT]) || (target_enabled == 5'h00);
		end
	end
	// chain reset drives only sensor_regs_clear, not the rate, accel or temp path clears
	assign rate_path_clear      = pulse_reg[0];
	assign accel_path_clear     = pulse_reg[1];
	assign temp_path_clear      = pulse_reg[2];
	assign sensor_regs_clear    = pulse_reg[3];
	assign fifo_clear           = pulse_reg[4];
	assign aux_master_clear     = pulse_reg[5];
	assign alloc_recompute      = pulse_reg[6];
	assign fifo_on              = feature_reg[`SHC_FEAT_FIFO_ON_BIT];
	assign aux_master_on        = feature_reg[`SHC_FEAT_AUX_ON_BIT];
	assign primary_port_disable = feature_reg[`SHC_FEAT_PORT_DIS_BIT];

	// ==========================================================
	// aux bus routing; primary lines are pins, so synchronised first
	logic [1:0] pd_sync;
	logic [1:0] pc_sync;
	logic       aux_d_reg;
	logic       aux_c_reg;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pd_sync <= 2'b11;
			pc_sync <= 2'b11;
		end
		else
		begin
			pd_sync <= {pd_sync[0], primary_data_in};
			pc_sync <= {pc_sync[0], primary_clock_in};
		end
	end
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			aux_d_reg <= 1'b1;
			aux_c_reg <= 1'b1;
		end
		else if (aux_master_on)
		begin
			aux_d_reg <= master_data_out;
			aux_c_reg <= master_clock_out;
		end
		else
		begin
			aux_d_reg <= pd_sync[1];
			aux_c_reg <= pc_sync[1];
		end
	end
	assign aux_bus_data_line  = aux_d_reg;
	assign aux_bus_clock_line = aux_c_reg;

	// ==========================================================
	// base sample tick
	// divider plus filter setting; filter off (0 or 7) adds a further divide by 8, filter on counts sensor_tick directly
	logic [15:0] rate_cnt;
	logic        sample_tick;
	logic [15:0] rate_top;
	assign rate_top = (lowpass_filter_config == 3'h0 || lowpass_filter_config == 3'h7)
		? {5'h00, sample_rate_divider, 3'h7} : {8'h00, sample_rate_divider};
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rate_cnt    <= 16'h0000;
			sample_tick <= 1'b0;
		end
		else
		begin
			sample_tick <= 1'b0;
			if (sensor_tick)
			begin
				if (rate_cnt >= rate_top)
				begin
					rate_cnt    <= 16'h0000;
					sample_tick <= 1'b1;
				end
				else
					rate_cnt <= rate_cnt + 16'h0001;
			end
		end
	end

	// ==========================================================
	// per-target pacing
	logic [4:0] skip_cnt;
	logic [4:0] access_reg;
	// one access per 1 + divider samples
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			skip_cnt <= 5'h00;
		else if (sample_tick)
			skip_cnt <= (skip_cnt >= slow_access_divider) ? 5'h00 : skip_cnt + 5'h01;
	end
	// slowed targets wait for the shared divider
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			access_reg <= 5'h00;
		else
			for (int i = 0; i < `SHC_NUM_TARGETS; i++)
				access_reg[i] <= sample_tick && target_enabled[i] && aux_master_on
					&& (!pacing_reg[i] || skip_cnt == 5'h00);
	end
	assign target_access = access_reg;

	// shadow copy deferred to end of set
	logic shadow_reg;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			shadow_reg <= 1'b0;
		else if (pacing_reg[`SHC_PACE_DEFER_BIT])
			shadow_reg <= aux_set_done;
		else
			shadow_reg <= sample_tick || aux_set_done;
	end
	assign shadow_copy = shadow_reg;

	// ==========================================================
	// accel wake sequence
	shc_wake_t   wake_state;
	logic [31:0] wake_cnt;
	logic [2:0]  flush_cnt;
	logic [31:0] wake_total;
	// 4 ms base plus extra ms steps
	assign wake_total = 32'(WAKE_BASE_CYC) + 32'(WAKE_STEP_CYC) * {30'h0, detect_reg[5:4]};
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			wake_state <= SHC_WAKE_IDLE;
			wake_cnt   <= 32'h0;
			flush_cnt  <= 3'h0;
		end
		else if (!accel_wake || accel_path_clear)
			wake_state <= SHC_WAKE_IDLE;
		else
		begin
			unique case (wake_state)
				SHC_WAKE_IDLE:
				begin
					wake_cnt   <= 32'h1;
					wake_state <= SHC_WAKE_WAIT;
				end
				SHC_WAKE_WAIT:
				begin
					wake_cnt <= wake_cnt + 32'h1;
					if (wake_cnt >= wake_total)
					begin
						flush_cnt  <= 3'h0;
						wake_state <= SHC_WAKE_FLUSH;
					end
				end
				SHC_WAKE_FLUSH:
					if (accel_sample)
					begin
						flush_cnt <= flush_cnt + 3'h1;
						if (flush_cnt == 3'(`SHC_FLUSH_SAMPLES - 1))
							wake_state <= SHC_WAKE_RUN;
					end
				SHC_WAKE_RUN: wake_state <= SHC_WAKE_RUN;
			endcase
		end
	end
	logic active_reg;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			active_reg <= 1'b0;
		else
			active_reg <= (wake_state == SHC_WAKE_RUN) && accel_wake;
	end
	assign detect_active = active_reg;

	// ==========================================================
	// detection counters
	function automatic logic [7:0] shc_step(input logic [7:0] c, input logic q, input logic [1:0] s);
		logic [7:0] d;
		d = 8'h00;
		if (q)
			return (c == 8'hff) ? c : c + 8'h01;
		unique case (s)
			2'h0: d = c;
			2'h1: d = 8'h01;
			2'h2: d = 8'h02;
			2'h3: d = 8'h04;
		endcase
		return (c > d) ? c - d : 8'h00;
	endfunction

	logic [7:0] ff_cnt;
	logic [7:0] mot_cnt;
	logic       ff_det;
	logic       mot_det;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ff_cnt  <= 8'h00;
			mot_cnt <= 8'h00;
			ff_det  <= 1'b0;
			mot_det <= 1'b0;
		end
		else if (!active_reg)
		begin
			ff_cnt  <= 8'h00;
			mot_cnt <= 8'h00;
			ff_det  <= 1'b0;
			mot_det <= 1'b0;
		end
		else if (accel_sample)
		begin
			ff_cnt  <= shc_step(ff_cnt, freefall_qualify, detect_reg[3:2]);
			mot_cnt <= shc_step(mot_cnt, motion_qualify, detect_reg[1:0]);
			ff_det  <= freefall_qualify && (ff_cnt + 8'h01 >= freefall_duration);
			mot_det <= motion_qualify && (mot_cnt + 8'h01 >= motion_duration);
		end
		else
		begin
			ff_det  <= 1'b0;
			mot_det <= 1'b0;
		end
	end
	assign freefall_count  = ff_cnt;
	assign motion_count    = mot_cnt;
	assign freefall_detect = ff_det;
	assign motion_detect   = mot_det;

endmodule : shc_control_regs

//--- shc_host.sv
// Purpose: host model on the register port of the control bank
// Assumes: one access per call, clk rising edge sampling
// Notes:   strobes change only right after rising edges
`timescale 1ns/100ps
module shc_host
	import shc_pkg::*;
(
	// clock
	input  wire logic       clk,
	// register port
	input  wire logic [7:0] rdata,
	output logic      [7:0] addr,
	output logic      [7:0] wdata,
	output logic            wr,
	output logic            rd
);
	initial
	begin
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
	end

	// ========
	// bus cycles
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	// data stands only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		// settled value, not the one the next edge replaces
		#1;
		d = rdata;
	endtask : rd_reg
endmodule : shc_host

//--- shc_regs_chk.sv
// Purpose: port-level checks of the control bank
// Assumes: one clock, rstn async active low
// Notes:   detect selects tracked from host writes
`timescale 1ns/100ps
module shc_regs_chk
	import shc_pkg::*;
(
	// clock and reset
	input wire logic       clk,
	input wire logic       rstn,
	// host port
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic [7:0] rdata,
	// detection
	input wire logic       accel_sample,
	input wire logic       freefall_qualify,
	input wire logic       motion_qualify,
	input wire logic       detect_active,
	input wire logic [7:0] freefall_count,
	input wire logic [7:0] motion_count,
	// control outputs and the inputs they follow
	input wire logic [4:0] target_enabled,
	input wire logic       alloc_recompute,
	input wire logic       accel_path_clear,
	input wire logic       fifo_clear,
	input wire logic       fifo_on,
	input wire logic       aux_master_on,
	input wire logic       master_data_out,
	input wire logic       aux_bus_data_line
);
	logic [7:0] det_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	// ========
	// shadow of the detect register, only its selects matter
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
			det_q <= 8'h00;
		else if (wr && addr == 8'h69)
			det_q <= wdata;

	// ========
	// assertions
	property p_path_clr; wr && addr == 8'h68 && wdata[1] |=> accel_path_clear; endproperty
	a_path_clr: assert property (p_path_clr) else $error("accel path clear missing");
	property p_fifo_gate; fifo_clear |-> $past(wr && addr == 8'h6a && wdata[2] && !fifo_on); endproperty
	a_fifo_gate: assert property (p_fifo_gate) else $error("fifo clear without cause");
	property p_self_clr; rd && addr == 8'h6a |=> (rdata & 8'h8f) == 8'h00; endproperty
	a_self_clr: assert property (p_self_clr) else $error("feature reset bits read back");
	property p_det_rsv; rd && addr == 8'h69 |=> rdata[7:6] == 2'b00; endproperty
	a_det_rsv: assert property (p_det_rsv) else $error("detect reserved bits set");
	property p_mux; aux_master_on && $past(aux_master_on) |-> aux_bus_data_line == $past(master_data_out); endproperty
	a_mux: assert property (p_mux) else $error("aux data not from master");
	property p_inc;
		accel_sample && motion_qualify && detect_active && motion_count != 8'hff
		|=> motion_count == $past(motion_count) + 8'h01;
	endproperty
	a_inc: assert property (p_inc) else $error("motion count not incremented");
	property p_zero; accel_sample && !freefall_qualify && detect_active && det_q[3:2] == 2'b00 |=> freefall_count == 8'h00; endproperty
	a_zero: assert property (p_zero) else $error("freefall count not zeroed");
	property p_alloc; target_enabled == 5'h00 |=> alloc_recompute; endproperty
	a_alloc: assert property (p_alloc) else $error("allocation not recomputed");
endmodule : shc_regs_chk

bind shc_control_regs shc_regs_chk u_shc_regs_chk (
	.clk, .rstn, .addr, .wdata, .wr, .rd, .rdata, .accel_sample, .freefall_qualify,
	.motion_qualify, .detect_active, .freefall_count, .motion_count, .target_enabled,
	.alloc_recompute, .accel_path_clear, .fifo_clear, .fifo_on, .aux_master_on,
	.master_data_out, .aux_bus_data_line
);

//--- tb.sv
// Purpose: self-checking bench for the control bank
// Assumes: 10 MHz clock, wake counts shortened to 40 and 10
// Notes:   registers reached through shc_host
`timescale 1ns/100ps
module tb
	import shc_pkg::*;
;
	logic clk, rstn = 1'b0, tick = 1'b0, done = 1'b0, wake = 1'b0, smp = 1'b0, ffq = 1'b0, mq = 1'b0;
	logic pd = 1'b1, pc = 1'b1, md = 1'b0, mc = 1'b0, wr, rd;
	logic [7:0] addr, wdata, rdata, ffc, mtc, srd = 8'h00, ffd = 8'h03, mdur = 8'h05;
	logic [2:0] lpf = 3'h1;
	logic [4:0] sad = 5'h00, ten = 5'h1f, tac;
	logic shc, alc, act, ffx, mtx, rpc, apc, tpc, src, fcl, amc, fon, aon, ppd, ad, ac;
	int fails = 0, check_count = 0, n0 = 0, n1 = 0, ns = 0, nf = 0, nm = 0;

	shc_control_regs #(.WAKE_BASE_CYC(40), .WAKE_STEP_CYC(10)) u_shc_control_regs (
		.clk, .rstn, .addr, .wdata, .wr, .rd, .rdata, .sample_rate_divider(srd),
		.lowpass_filter_config(lpf), .slow_access_divider(sad), .sensor_tick(tick),
		.target_enabled(ten), .aux_set_done(done), .target_access(tac), .shadow_copy(shc),
		.alloc_recompute(alc), .accel_wake(wake), .accel_sample(smp), .freefall_qualify(ffq),
		.motion_qualify(mq), .freefall_duration(ffd), .motion_duration(mdur), .detect_active(act),
		.freefall_count(ffc), .motion_count(mtc), .freefall_detect(ffx), .motion_detect(mtx),
		.rate_path_clear(rpc), .accel_path_clear(apc), .temp_path_clear(tpc),
		.sensor_regs_clear(src), .fifo_clear(fcl), .aux_master_clear(amc), .fifo_on(fon),
		.aux_master_on(aon), .primary_port_disable(ppd), .primary_data_in(pd),
		.primary_clock_in(pc), .master_data_out(md), .master_clock_out(mc),
		.aux_bus_data_line(ad), .aux_bus_clock_line(ac));
	shc_host u_shc_host (.clk, .rdata, .addr, .wdata, .wr, .rd);

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// pulse tallies, zeroed by the tests
	always @(posedge clk)
	begin
		n0 += tac[0];
		n1 += tac[1];
		ns += shc;
		nf += ffx;
		nm += mtx;
	end

	// ========
	// helpers
	task automatic ck(input logic [7:0] g, input logic [7:0] e);
		check_count++;
		if (g !== e)
		begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask : ck

	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		u_shc_host.rd_reg(a, d);
		ck(d, e);
	endtask : rc

	// returns just after the write edge so pulses can be seen
	task automatic wc(input logic [7:0] a, input logic [7:0] d);
		u_shc_host.wr_reg(a, d);
		#1;
	endtask : wc

	task automatic tk(input int n);
		repeat (n)
		begin
			@(posedge clk);
			tick <= 1'b1;
			@(posedge clk);
			tick <= 1'b0;
			repeat (3) @(posedge clk);
		end
	endtask : tk

	task automatic sm(input logic q);
		@(posedge clk);
		smp <= 1'b1;
		ffq <= q;
		mq <= q;
		@(posedge clk);
		smp <= 1'b0;
		repeat (2) @(posedge clk);
	endtask : sm

	// ========
	// tests
	task automatic t_regs;
		rc(8'h67, 8'h00);
		rc(8'h69, 8'h00);
		rc(8'h6a, 8'h00);
		wc(8'h67, 8'hff);
		rc(8'h67, 8'h9f);
		wc(8'h69, 8'hff);
		rc(8'h69, 8'h3f);
		wc(8'h68, 8'h00);
		rc(8'h68, 8'h00);
		rc(8'h55, 8'h00);
		$display("t_regs done");
	endtask : t_regs

	task automatic t_clr;
		wc(8'h68, 8'h07);
		ck({5'h00, rpc, apc, tpc}, 8'h07);
		ck({7'h00, src}, 8'h00);
		@(posedge clk);
		#1;
		ck({5'h00, rpc, apc, tpc}, 8'h00);
		wc(8'h6a, 8'h07);
		ck({5'h00, fcl, amc, src}, 8'h07);
		rc(8'h6a, 8'h00);
		wc(8'h6a, 8'h40);
		wc(8'h6a, 8'h44);
		ck({6'h00, fon, fcl}, 8'h02);
		rc(8'h6a, 8'h40);
		wc(8'h6a, 8'h00);
		wc(8'h6a, 8'h04);
		ck({7'h00, fcl}, 8'h01);
		$display("t_clr done");
	endtask : t_clr

	task automatic t_mux;
		@(posedge clk);
		pd <= 1'b0;
		md <= 1'b1;
		repeat (5) @(posedge clk);
		ck({6'h00, ad, ac}, 8'h01);
		wc(8'h6a, 8'h20);
		repeat (3) @(posedge clk);
		ck({6'h00, ad, ac}, 8'h02);
		$display("t_mux done");
	endtask : t_mux

	task automatic t_pace;
		@(posedge clk);
		sad <= 5'h02;
		wc(8'h67, 8'h81);
		n0 = 0;
		n1 = 0;
		ns = 0;
		tk(6);
		ck(n0[7:0], 8'h02);
		ck(n1[7:0], 8'h06);
		ck(ns[7:0], 8'h00);
		@(posedge clk);
		done <= 1'b1;
		@(posedge clk);
		done <= 1'b0;
		lpf <= 3'h0;
		repeat (3) @(posedge clk);
		ck(ns[7:0], 8'h01);
		wc(8'h67, 8'h00);
		ns = 0;
		tk(16);
		ck(ns[7:0], 8'h02);
		@(posedge clk);
		ten <= 5'h00;
		repeat (2) @(posedge clk);
		ck({7'h00, alc}, 8'h01);
		ten <= 5'h1f;
		$display("t_pace done");
	endtask : t_pace

	task automatic t_wake;
		wc(8'h69, 8'h20);
		@(posedge clk);
		wake <= 1'b1;
		repeat (56) @(posedge clk);
		ck({7'h00, act}, 8'h00);
		// first sample lands inside the wait, so only three reach the flush
		repeat (4) sm(1'b0);
		ck({7'h00, act}, 8'h00);
		sm(1'b0);
		ck({7'h00, act}, 8'h01);
		$display("t_wake done");
	endtask : t_wake

	task automatic t_cnt;
		logic [7:0] ex [4] = '{8'h00, 8'h04, 8'h03, 8'h01};
		nf = 0;
		nm = 0;
		for (int c = 0; c < 4; c++)
		begin
			wc(8'h69, 8'h20);
			sm(1'b0);
			wc(8'h69, {2'b00, 2'b10, c[1:0], c[1:0]});
			repeat (5) sm(1'b1);
			ck(ffc, 8'h05);
			sm(1'b0);
			ck(ffc, ex[c]);
			ck(mtc, ex[c]);
		end
		ck(nf[7:0], 8'h0c);
		ck(nm[7:0], 8'h04);
		@(posedge clk);
		wake <= 1'b0;
		repeat (2) @(posedge clk);
		ck({7'h00, act}, 8'h00);
		$display("t_cnt done");
	endtask : t_cnt

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : report_and_stop

	// ========
	// main sequence and watchdog
	initial
	begin
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		t_regs();
		t_clr();
		t_mux();
		t_pace();
		t_wake();
		t_cnt();
		report_and_stop();
	end

	// runs take under 2000 cycles
	initial
	begin
		repeat (20000) @(posedge clk);
		fails++;
		report_and_stop();
	end
endmodule : tb
